// *** core/nvsw_defines.svh ***
// Purpose: named offsets, field positions, reset values and timings
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   numbers only; types live in nvsw_pkg
`ifndef NVSW_DEFINES_SVH
`define NVSW_DEFINES_SVH
// register byte addresses
`define NVSW_OFS_PTR_LOW   8'h00
`define NVSW_OFS_PTR_HIGH  8'h04
`define NVSW_OFS_PTR_UPPER 8'h08
`define NVSW_OFS_LATCH     8'h0c
`define NVSW_OFS_TBL_WRITE 8'h10
`define NVSW_OFS_INTCTL    8'h14
`define NVSW_OFS_UNLOCK    8'h18
`define NVSW_OFS_MEMCTL    8'h1c
`define NVSW_OFS_PRIO2     8'h20
`define NVSW_OFS_FLAGS2    8'h24
`define NVSW_OFS_ENABLE2   8'h28
`define NVSW_OFS_EE_DATA   8'h2c
`define NVSW_OFS_EE_ADDR   8'h30
// memory control bit positions
`define NVSW_MC_PGM   7
`define NVSW_MC_CFG   6
`define NVSW_MC_RSVD  5
`define NVSW_MC_FREE  4
`define NVSW_MC_ERR   3
`define NVSW_MC_ARM   2
`define NVSW_MC_WR    1
`define NVSW_MC_RD    0
// done flag position in flags/enables/priority two
`define NVSW_DONE_BIT 4
// implemented bits and reset values of the peripheral two group
`define NVSW_P2_MASK   8'h95
`define NVSW_PRIO2_RST 8'h95
// unlock sequence bytes
`define NVSW_KEY_FIRST  8'h55
`define NVSW_KEY_SECOND 8'haa
// timing and erased eeprom value
`define NVSW_CLK_MHZ        50
`define NVSW_FLASH_WR_US    2000
`define NVSW_EE_WR_US       4000
`define NVSW_EE_ERASED      8'hff
`endif

// *** core/nvsw_pkg.sv ***
// Purpose: shared types of the nonvolatile self-write controller
// Assumes: used together with nvsw_defines.svh
// Notes:   enums carry no explicit codes
package nvsw_pkg;
  // sequencer state
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FLASH, SEQ_EE} nvsw_seq_type;
  // unlock progress
  typedef enum logic [1:0] {ULK_IDLE, ULK_FIRST, ULK_ARMED} nvsw_ulk_type;
  // table write pointer modes, low two bits of the command word
  typedef enum logic [1:0] {TW_HOLD, TW_POST_INC, TW_POST_DEC, TW_PRE_INC} nvsw_tw_type;
  // block programming strobe toward the flash array
  typedef struct packed {
    logic        strobe;
    logic [18:0] block_addr;
    logic [63:0] data;
  } nvsw_prog_type;
  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } nvsw_apb_req_type;
  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } nvsw_apb_rsp_type;
endpackage

// *** core/nvsw_top.sv ***
// Purpose: self-write controller for on-chip flash and data eeprom
// Assumes: 50 MHz clk_i, synchronous active-high sys_rst_i, apb slave
// Notes:   eeprom storage is flip-flops; flash array sits outside
// Notes on behaviour
// - flash is programmed only as whole 8-byte blocks, never bytes or words
// - eight byte-wide holding registers collect data for the next block
// - a table write only updates the addressed holding register
// - instruction execution halts during a long flash write, resumes afterwards; eeprom writes do not halt it
// - an internal timer ends each long write, about 2 ms for flash
// - write-start after a valid unlock begins the timed block write
// - a master-clear or watchdog reset during a write sets the abort flag
// - pointer bit 21 only in test mode; upper byte holds six bits
// - pointer bytes and table latch clear on every reset
// - memory control resets fully on power-on, keeps selects and flag otherwise
// - 256 eeprom bytes reached through data and address registers
// - an eeprom byte write erases first, timed by an on-chip timer
// - the eeprom is reached only indirectly through its registers
// - every write needs the exact 55h, 0AAh, write-start sequence
// - write-start is software-set only, hardware-cleared, blocked without write arm; with cfg set and pgm clear nothing runs and wr stays set until reset
// - completion sets the done flag, which stays until software clears it
`timescale 1ns/1ns
`include "nvsw_defines.svh"

module nvsw_top #(
  parameter int FLASH_WR_CYCLES = `NVSW_FLASH_WR_US * `NVSW_CLK_MHZ,
  parameter int EE_WR_CYCLES    = `NVSW_EE_WR_US * `NVSW_CLK_MHZ
) (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      por_i,
  input  wire logic                      abort_reset_i,
  input  wire logic                      test_mode_i,
  input  wire nvsw_pkg::nvsw_apb_req_type apb_req_i,
  output      nvsw_pkg::nvsw_apb_rsp_type apb_rsp_o,
  output      logic                      stall_o,
  output      nvsw_pkg::nvsw_prog_type    prog_o
);
  import nvsw_pkg::*;

  // one timer serves both write kinds, so it is sized for the longer one;
  // two timers would cost flops and buy nothing, as only one write runs at a time
  localparam int MAX_CYC = (FLASH_WR_CYCLES > EE_WR_CYCLES) ? FLASH_WR_CYCLES : EE_WR_CYCLES;
  localparam int CW      = $clog2(MAX_CYC + 1);

  // the timer cannot run a write of zero cycles
  if (FLASH_WR_CYCLES < 1 || EE_WR_CYCLES < 1) begin : g_chk
    $error("nvsw_top: write times must be at least one cycle");
  end

  nvsw_seq_type     seq;
  nvsw_ulk_type     ulk;
  logic [CW-1:0]    timer;
  logic [21:0]      table_pointer;
  logic [7:0]       table_byte_latch;
  logic [7:0]       hold [8];
  logic [7:0]       interrupt_control;
  logic [7:0]       memory_control;
  logic [7:0]       peripheral_priority_two;
  logic [7:0]       peripheral_flags_two;
  logic [7:0]       peripheral_enables_two;
  logic [7:0]       eeprom_data_reg;
  logic [7:0]       eeprom_address_reg;
  logic [7:0]       ee_mem [256];
  logic             test_meta;
  logic             test_sync;
  logic             rd_pend;
  logic             done_evt;
  logic             acc;
  logic             wr_acc;
  logic             busy;
  logic             start_wr;
  logic             hit;
  logic [7:0]       ofs;
  logic [7:0]       wb;
  logic [7:0]       rd_byte;
  logic [20:0]      ptr_inc;
  logic [20:0]      ptr_dec;
  logic [2:0]       hold_idx;

  // test mode is a pin: two flops before anything reads it
  always_ff @(posedge clk_i) begin
    test_meta <= test_mode_i;
    test_sync <= test_meta;
  end

  // one access per transfer, taken at the edge where pready is high
  assign acc    = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready;
  assign wr_acc = acc & apb_req_i.pwrite;
  assign ofs    = apb_req_i.paddr;
  assign wb     = apb_req_i.pwdata[7:0];
  assign busy   = (seq != SEQ_IDLE);
  assign ptr_inc = table_pointer[20:0] + 21'h000001;
  assign ptr_dec = table_pointer[20:0] - 21'h000001;

  // start only with arm already set and the unlock armed; wr and arm
  // in one write cannot start, since the old arm value is checked
  assign start_wr = wr_acc && ofs == `NVSW_OFS_MEMCTL && wb[`NVSW_MC_WR] && !busy
                    && memory_control[`NVSW_MC_ARM] && ulk == ULK_ARMED;

  // address decode and read data
  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    unique case (ofs)
      `NVSW_OFS_PTR_LOW:   rd_byte = table_pointer[7:0];
      `NVSW_OFS_PTR_HIGH:  rd_byte = table_pointer[15:8];
      `NVSW_OFS_PTR_UPPER: rd_byte = {2'b00, table_pointer[21:16]};
      `NVSW_OFS_LATCH:     rd_byte = table_byte_latch;
      `NVSW_OFS_TBL_WRITE: rd_byte = 8'h00;
      `NVSW_OFS_INTCTL:    rd_byte = interrupt_control;
      `NVSW_OFS_UNLOCK:    rd_byte = 8'h00;
      `NVSW_OFS_MEMCTL:    rd_byte = memory_control;
      `NVSW_OFS_PRIO2:     rd_byte = peripheral_priority_two;
      `NVSW_OFS_FLAGS2:    rd_byte = peripheral_flags_two;
      `NVSW_OFS_ENABLE2:   rd_byte = peripheral_enables_two;
      `NVSW_OFS_EE_DATA:   rd_byte = eeprom_data_reg;
      `NVSW_OFS_EE_ADDR:   rd_byte = eeprom_address_reg;
      default:             hit = 1'b0;
    endcase
  end

  // apb answer: one wait state, held off while a flash write halts the cpu
  // read data is captured on the wait-state edge and shown together with pready
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o.pready  <= apb_req_i.psel & apb_req_i.penable & ~apb_rsp_o.pready
                           & ~(seq == SEQ_FLASH);
      apb_rsp_o.pslverr <= apb_req_i.psel & apb_req_i.penable & ~apb_rsp_o.pready & ~hit;
      apb_rsp_o.prdata  <= {24'h000000, rd_byte};
    end
  end

  // unlock tracker: any other write in between breaks the sequence
  // reads do not break it, so software may poll between the two keys
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ulk <= ULK_IDLE;
    end else if (wr_acc) begin
      if (ofs == `NVSW_OFS_UNLOCK && wb == `NVSW_KEY_FIRST) begin
        ulk <= ULK_FIRST;
      end else if (ofs == `NVSW_OFS_UNLOCK && wb == `NVSW_KEY_SECOND && ulk == ULK_FIRST) begin
        ulk <= ULK_ARMED;
      end else begin
        ulk <= ULK_IDLE;
      end
    end
  end

  // sequencer and programming timer
  // the timer loads n-1 so that expiry lands n cycles after the start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      seq      <= SEQ_IDLE;
      timer    <= '0;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      unique case (seq)
        SEQ_IDLE: begin
          if (start_wr && memory_control[`NVSW_MC_PGM]) begin
            seq   <= SEQ_FLASH;
            timer <= CW'(FLASH_WR_CYCLES - 1);
          end else if (start_wr && !memory_control[`NVSW_MC_CFG]) begin
            seq   <= SEQ_EE;
            timer <= CW'(EE_WR_CYCLES - 1);
          end
        end
        SEQ_FLASH, SEQ_EE: begin
          if (timer == '0) begin
            seq      <= SEQ_IDLE;
            done_evt <= 1'b1;
          end else begin
            timer <= timer - CW'(1);
          end
        end
      endcase
    end
  end

  // stall follows the flash write, dropping on the expiry edge itself; it is
  // already low when the block strobe shows, so the cpu resumes as the
  // array is told to program
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stall_o <= 1'b0;
    end else if (start_wr && memory_control[`NVSW_MC_PGM]) begin
      stall_o <= 1'b1;
    end else if (seq == SEQ_FLASH && timer == '0) begin
      stall_o <= 1'b0;
    end
  end

  // block strobe to the flash array: 19 upper pointer bits, 8 bytes at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prog_o <= '0;
    end else begin
      prog_o.strobe <= (seq == SEQ_FLASH && timer == '0);
      if (seq == SEQ_FLASH && timer == '0) begin
        prog_o.block_addr <= table_pointer[21:3];
        prog_o.data <= {hold[7], hold[6], hold[5], hold[4],
                        hold[3], hold[2], hold[1], hold[0]};
      end
    end
  end

  // table pointer; automatic steps touch only the low 21 bits
  // pre-increment selects the register after the step, the others before it
  assign hold_idx = (wb[1:0] == TW_PRE_INC) ? ptr_inc[2:0] : table_pointer[2:0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      table_pointer <= '0;
    end else if (wr_acc && !busy) begin
      unique case (ofs)
        `NVSW_OFS_PTR_LOW:  table_pointer[7:0]   <= wb;
        `NVSW_OFS_PTR_HIGH: table_pointer[15:8]  <= wb;
        `NVSW_OFS_PTR_UPPER: begin
          table_pointer[20:16] <= wb[4:0];
          // outside test mode the top bit keeps its value, a stale one survives
          if (test_sync) begin
            table_pointer[21] <= wb[5];
          end
        end
        `NVSW_OFS_TBL_WRITE: begin
          if (wb[1:0] == TW_POST_INC || wb[1:0] == TW_PRE_INC) begin
            table_pointer[20:0] <= ptr_inc;
          end else if (wb[1:0] == TW_POST_DEC) begin
            table_pointer[20:0] <= ptr_dec;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // table latch
  // only software fills it here; the read path is kept outside this block
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      table_byte_latch <= '0;
    end else if (wr_acc && ofs == `NVSW_OFS_LATCH) begin
      table_byte_latch <= wb;
    end
  end

  // holding registers: a short write that never reaches the array
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 8; i++) begin
        hold[i] <= 8'h00;
      end
    end else if (wr_acc && !busy && ofs == `NVSW_OFS_TBL_WRITE) begin
      hold[hold_idx] <= table_byte_latch;
    end
  end

  // memory control; on a warm reset the selects and error flag survive
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      if (por_i) begin
        memory_control <= 8'h00;
      end else begin
        memory_control[`NVSW_MC_FREE] <= 1'b0;
        memory_control[`NVSW_MC_ARM]  <= 1'b0;
        memory_control[`NVSW_MC_WR]   <= 1'b0;
        memory_control[`NVSW_MC_RD]   <= 1'b0;
        memory_control[`NVSW_MC_RSVD] <= 1'b0;
        if (busy && abort_reset_i) begin
          memory_control[`NVSW_MC_ERR] <= 1'b1;
        end
      end
    end else begin
      if (wr_acc && ofs == `NVSW_OFS_MEMCTL && !busy) begin
        memory_control[`NVSW_MC_PGM]  <= wb[`NVSW_MC_PGM];
        memory_control[`NVSW_MC_CFG]  <= wb[`NVSW_MC_CFG];
        memory_control[`NVSW_MC_FREE] <= wb[`NVSW_MC_FREE];
        memory_control[`NVSW_MC_ERR]  <= wb[`NVSW_MC_ERR];
        memory_control[`NVSW_MC_ARM]  <= wb[`NVSW_MC_ARM];
        memory_control[`NVSW_MC_RD]   <= wb[`NVSW_MC_RD] & ~wb[`NVSW_MC_PGM];
      end else if (wr_acc && ofs == `NVSW_OFS_MEMCTL) begin
        // arm may drop during a write; it does not stop the write
        memory_control[`NVSW_MC_ARM] <= wb[`NVSW_MC_ARM];
      end else if (rd_pend) begin
        memory_control[`NVSW_MC_RD] <= 1'b0;
      end
      if (start_wr) begin
        memory_control[`NVSW_MC_WR] <= 1'b1;
      end else if (busy && timer == '0) begin
        memory_control[`NVSW_MC_WR]   <= 1'b0;
        memory_control[`NVSW_MC_FREE] <= 1'b0;
      end
    end
  end

  // eeprom read completes the cycle after rd is set
  // rd stays set for two cycles, so a back-to-back read of memory control can still see it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= memory_control[`NVSW_MC_RD] & ~rd_pend;
    end
  end

  // eeprom data and address registers; software writes to them are ignored while a write runs
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      eeprom_data_reg    <= '0;
      eeprom_address_reg <= '0;
    end else if (rd_pend) begin
      eeprom_data_reg <= ee_mem[eeprom_address_reg];
    end else if (wr_acc && !busy && ofs == `NVSW_OFS_EE_DATA) begin
      eeprom_data_reg <= wb;
    end else if (wr_acc && !busy && ofs == `NVSW_OFS_EE_ADDR) begin
      eeprom_address_reg <= wb;
    end
  end

  // eeprom array: erase at start, new byte at the end of the timed write
  // no reset here: the array keeps its contents across every reset
  always_ff @(posedge clk_i) begin
    if (start_wr && !memory_control[`NVSW_MC_PGM] && !memory_control[`NVSW_MC_CFG]) begin
      ee_mem[eeprom_address_reg] <= `NVSW_EE_ERASED;
    end else if (seq == SEQ_EE && timer == '0) begin
      ee_mem[eeprom_address_reg] <= eeprom_data_reg;
    end
  end

  // interrupt control is plain storage here; no interrupt logic in this block
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      interrupt_control <= 8'h00;
    end else if (wr_acc && ofs == `NVSW_OFS_INTCTL) begin
      interrupt_control <= wb;
    end
  end

  // peripheral group two; completion beats a clear in the same cycle
  // only the implemented bits are stored, the rest read as zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      peripheral_priority_two <= `NVSW_PRIO2_RST;
      peripheral_flags_two    <= 8'h00;
      peripheral_enables_two  <= 8'h00;
    end else begin
      if (wr_acc && ofs == `NVSW_OFS_PRIO2) begin
        peripheral_priority_two <= wb & `NVSW_P2_MASK;
      end
      if (wr_acc && ofs == `NVSW_OFS_ENABLE2) begin
        peripheral_enables_two <= wb & `NVSW_P2_MASK;
      end
      if (wr_acc && ofs == `NVSW_OFS_FLAGS2) begin
        peripheral_flags_two <= wb & `NVSW_P2_MASK;
      end
      if (done_evt) begin
        peripheral_flags_two[`NVSW_DONE_BIT] <= 1'b1;
      end
    end
  end

endmodule

// *** verification/nvsw_top_asserts.sv ***
// Purpose: port-level timing checks of the self-write controller
// Assumes: one clock, synchronous active-high reset, apb slave side
// Notes:   the stall span is measured by a counter, not a long repetition
`timescale 1ns/1ns
`include "nvsw_defines.svh"
module nvsw_top_asserts #(
  parameter int FLASH_WR_CYCLES = 100000,
  parameter int EE_WR_CYCLES    = 200000
) (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire logic                       por_i,
  input wire logic                       abort_reset_i,
  input wire logic                       test_mode_i,
  input wire nvsw_pkg::nvsw_apb_req_type apb_req_i,
  input wire nvsw_pkg::nvsw_apb_rsp_type apb_rsp_o,
  input wire logic                       stall_o,
  input wire nvsw_pkg::nvsw_prog_type    prog_o
);
  import nvsw_pkg::*;
  logic [31:0] stall_cnt;
  logic        start_taken;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // counts stalled cycles so the whole long write can be judged at its end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !stall_o) stall_cnt <= 32'h0;
    else stall_cnt <= stall_cnt + 32'h1;
  end
  // a memory control write with start and program select taken this cycle
  assign start_taken = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready &&
    apb_req_i.pwrite && apb_req_i.paddr == `NVSW_OFS_MEMCTL &&
    apb_req_i.pwdata[`NVSW_MC_WR] && apb_req_i.pwdata[`NVSW_MC_PGM];
  property p_err_ready; apb_rsp_o.pslverr |-> apb_rsp_o.pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_unmapped; apb_rsp_o.pready && apb_req_i.paddr > `NVSW_OFS_EE_ADDR |-> apb_rsp_o.pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_byte_data; apb_rsp_o.pready |-> apb_rsp_o.prdata[31:8] == 24'h0; endproperty
  a_byte_data: assert property (p_byte_data) else $error("upper read bits set");
  property p_ready_access; apb_rsp_o.pready |-> apb_req_i.psel && apb_req_i.penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_strobe_pulse; prog_o.strobe |=> !prog_o.strobe; endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_strobe_stall; prog_o.strobe |-> $past(stall_o) && !stall_o; endproperty
  a_strobe_stall: assert property (p_strobe_stall) else $error("strobe without stall");
  property p_stall_drop; prog_o.strobe |-> ##[1:2] !stall_o; endproperty
  a_stall_drop: assert property (p_stall_drop) else $error("stall held after write");
  property p_stall_len;
    $fell(stall_o) |-> stall_cnt >= FLASH_WR_CYCLES - 1 && stall_cnt <= FLASH_WR_CYCLES + 3;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_no_ready_stall;
    stall_o && !prog_o.strobe && !$past(prog_o.strobe) |-> !apb_rsp_o.pready;
  endproperty
  a_no_ready_stall: assert property (p_no_ready_stall) else $error("bus answered in stall");
  property p_start_cause; $rose(stall_o) |-> $past(start_taken) || $past(start_taken, 2);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("stall without start");
endmodule
bind nvsw_top nvsw_top_asserts #(
  .FLASH_WR_CYCLES(FLASH_WR_CYCLES),
  .EE_WR_CYCLES   (EE_WR_CYCLES)
) nvsw_top_asserts_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .abort_reset_i(abort_reset_i),
  .test_mode_i(test_mode_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .stall_o(stall_o), .prog_o(prog_o)
);

// *** verification/nvm_self_write_control_bench.sv ***
// Purpose: directed register-level bench of the self-write controller
// Assumes: apb slave with wait states, shortened write timers
// Notes:   expectations follow the register rules, never design outputs
`timescale 1ns/1ns
`include "nvsw_defines.svh"
module nvm_self_write_control_bench;
  import nvsw_pkg::*;
  localparam int FLASH_CYC = 20;
  logic             clk_i, sys_rst_i, por_i, abort_reset_i, test_mode_i, stall_o;
  nvsw_apb_req_type req;
  nvsw_apb_rsp_type rsp;
  nvsw_prog_type    prog, got_prog;
  int               failures, check_count, strobes, n;
  logic [31:0]      rd;
  logic             err;
  logic [63:0]      exp_blk;
  time              t0;
  nvsw_top #(.FLASH_WR_CYCLES(FLASH_CYC), .EE_WR_CYCLES(30)) nvsw_top_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .por_i(por_i), .abort_reset_i(abort_reset_i),
    .test_mode_i(test_mode_i), .apb_req_i(req), .apb_rsp_o(rsp), .stall_o(stall_o),
    .prog_o(prog));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // keep the last block strobe, count them to catch stray programming
  always @(posedge clk_i) begin
    if (prog.strobe === 1'b1) begin
      strobes++;
      got_prog = prog;
    end
  end
  task automatic fail(input string m);
    failures++;
    $display("ERROR %0t: %s", $time, m);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; upper write bits set on purpose, they must be ignored
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'hffffff, d}};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.pready !== 1'b1 && k < 500);
    if (k >= 500) fail("no ready");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check_count++;
    if (rd !== {24'h0, e} || err !== 1'b0) fail($sformatf("read %h got %h want %h", a, rd, e));
  endtask
  task automatic cmp(input logic [63:0] g, input logic [63:0] e, input string m);
    check_count++;
    if (g !== e) fail($sformatf("%s got %h want %h", m, g, e));
  endtask
  // unlock keys then the memory control value
  task automatic go(input logic [7:0] mc);
    wr(`NVSW_OFS_UNLOCK, `NVSW_KEY_FIRST);
    wr(`NVSW_OFS_UNLOCK, `NVSW_KEY_SECOND);
    wr(`NVSW_OFS_MEMCTL, mc);
  endtask
  task automatic rst(input logic p, input logic ab);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    por_i <= p;
    abort_reset_i <= ab;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    por_i <= 1'b0;
    abort_reset_i <= 1'b0;
  endtask
  // main sequence
  initial begin
    req = '0;
    failures = 0;
    check_count = 0;
    strobes = 0;
    test_mode_i = 1'b0;
    abort_reset_i = 1'b0;
    sys_rst_i = 1'b1;
    por_i = 1'b1;
    rst(1'b1, 1'b0);
    for (int a = 0; a <= 48; a += 4) chk(8'(a), a == 32 ? 8'h95 : 8'h00);
    apb(1'b1, 8'h34, 8'h12);
    cmp(64'(err), 64'h1, "unmapped");
    $display("test reset values done");
    wr(8'h08, 8'hff);
    chk(8'h08, 8'h1f);
    test_mode_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr(8'h08, 8'hff);
    chk(8'h08, 8'h3f);
    // clear the top bit while test mode still lets it change
    wr(8'h08, 8'h00);
    chk(8'h08, 8'h00);
    test_mode_i <= 1'b0;
    $display("test pointer upper done");
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h27);
    for (int i = 0; i < 8; i++) begin
      exp_blk[i*8 +: 8] = 8'(i * 17 + 3);
      wr(8'h0c, 8'(i * 17 + 3));
      wr(8'h10, 8'h03);
    end
    chk(8'h00, 8'h2f);
    cmp(64'(strobes), 64'h0, "array written by table writes");
    wr(8'h1c, 8'h84);
    wr(8'h1c, 8'h86);
    chk(8'h1c, 8'h84);
    go(8'h86);
    t0 = $time;
    chk(8'h1c, 8'h84);
    cmp(64'(($time - t0) / 20 >= FLASH_CYC), 64'h1, "bus not stalled");
    cmp(64'(strobes), 64'h1, "block strobes");
    cmp(got_prog.data, exp_blk, "block data");
    cmp(64'(got_prog.block_addr), 64'h25, "block address");
    chk(8'h24, 8'h10);
    chk(8'h24, 8'h10);
    wr(8'h24, 8'h00);
    chk(8'h24, 8'h00);
    wr(8'h10, 8'h02);
    chk(8'h00, 8'h2e);
    wr(8'h10, 8'h01);
    chk(8'h00, 8'h2f);
    wr(8'h10, 8'h00);
    chk(8'h00, 8'h2f);
    // second round of the row: refill, unlock and write the next block
    for (int i = 0; i < 8; i++) begin
      wr(8'h0c, 8'h40 + 8'(i));
      wr(8'h10, 8'h03);
    end
    go(8'h86);
    chk(8'h1c, 8'h84);
    cmp(got_prog.data, 64'h4746454443424140, "second block data");
    cmp(64'(got_prog.block_addr), 64'h26, "second block address");
    wr(8'h1c, 8'h80);
    go(8'h82);
    repeat (FLASH_CYC + 5) @(posedge clk_i);
    chk(8'h1c, 8'h80);
    cmp(64'(strobes), 64'h2, "write without arm");
    $display("test flash block done");
    wr(8'h30, 8'h5a);
    wr(8'h2c, 8'hc3);
    wr(8'h1c, 8'h04);
    go(8'h06);
    wr(8'h2c, 8'h00);
    n = 0;
    do begin
      apb(1'b0, 8'h1c, 8'h00);
      n++;
    end while (rd[1] !== 1'b0 && n < 100);
    if (n >= 100) fail("eeprom write never ended");
    chk(8'h2c, 8'hc3);
    wr(8'h2c, 8'h00);
    wr(8'h1c, 8'h01);
    chk(8'h2c, 8'hc3);
    chk(8'h24, 8'h10);
    wr(8'h24, 8'h00);
    $display("test eeprom byte done");
    wr(8'h1c, 8'h84);
    go(8'h86);
    repeat (5) @(posedge clk_i);
    rst(1'b0, 1'b1);
    chk(8'h1c, 8'h88);
    chk(8'h04, 8'h00);
    cmp(64'(strobes), 64'h2, "aborted write programmed");
    rst(1'b1, 1'b0);
    chk(8'h1c, 8'h00);
    $display("test abort done");
    end_sim();
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    #(20 * 20000);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
